// ==== logic/rx_sync_pkg.sv ====
// What this block does
// - Bit offset field 000..111 picks bit 1 (or F-bit) through bit 8 of a slot.
// - Both sync pulses sit on one bit position of the receive output slots.
// - Frame sync position is slot offset (upper 7) over bit offset (low 3).
// - Frame offset joined to the 10-bit position gives the 15-bit multiframe position.
// - Positions apply whether sync pins are driven or accepted as inputs.
// - Slot offset field is position bits 9..3, slot number 0 to 127.
// - At 1536, 1544, 2048 kbps the slot field is the slot number directly.
// - At 4096 kbps bits 9..4 give the slot and bit 3 the group A/B.
// - At 8192 kbps bits 9..5 give the slot and bits 4..3 group A to D.
// - A position outside the timebase gives no pulse on either sync output.
// - Edge select 0 drives on rising, samples on falling; 1 the reverse.
// - In slip buffer bypass the sync pins are ignored when they are inputs.
package rx_sync_pkg;

    localparam logic [11:0] BIT_POS_IDX = 12'h0d2;
    localparam logic [11:0] SLOT_POS_IDX = 12'h0d3;
    localparam logic [11:0] CTRL_IDX = 12'h0d9;
    localparam logic [11:0] STATUS_IDX = 12'h0da;
    localparam logic [11:0] BIT_POS_ADDR = {BIT_POS_IDX[9:0], 2'b00};
    localparam logic [11:0] SLOT_POS_ADDR = {SLOT_POS_IDX[9:0], 2'b00};
    localparam logic [11:0] CTRL_ADDR = {CTRL_IDX[9:0], 2'b00};
    localparam logic [11:0] STATUS_ADDR = {STATUS_IDX[9:0], 2'b00};

    localparam logic [2:0] BIT_POS_RST = 3'h0;
    localparam logic [6:0] SLOT_POS_RST = 7'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Control register fields
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_SLIP_LSB = 4;
    localparam int CTRL_FS_IN_BIT = 6;
    localparam int CTRL_MS_IN_BIT = 7;
    // Status register fields
    localparam int STAT_RANGE_BIT = 0;
    localparam int STAT_FS_SEEN_BIT = 1;
    localparam int STAT_MS_SEEN_BIT = 2;
    localparam int STAT_SLOT_LSB = 4;
    localparam int STAT_GROUP_LSB = 11;

    localparam logic [1:0] SLIP_BYPASS = 2'h3;
    localparam logic [4:0] MF_FRAMES = 5'h18;

    localparam logic [10:0] LEN_1536 = 11'h0c0;
    localparam logic [10:0] LEN_1544 = 11'h0c1;
    localparam logic [10:0] LEN_2048 = 11'h100;
    localparam logic [10:0] LEN_4096 = 11'h200;
    localparam logic [10:0] LEN_8192 = 11'h400;

    typedef enum logic [2:0] {
        RATE_1536 = 3'b000,
        RATE_1544 = 3'b001,
        RATE_2048 = 3'b010,
        RATE_4096 = 3'b011,
        RATE_8192 = 3'b100
    } bus_rate_mode_e;

    typedef struct packed {
        logic [2:0] rate;
        logic edge_sel;
        logic [1:0] slip;
        logic fs_in;
        logic ms_in;
        logic [9:0] pos;
        logic [4:0] frame;
    } sync_cfg_s;

    localparam sync_cfg_s CFG_RST = '{3'h0, 1'b0, 2'h0, 1'b0, 1'b0, 10'h000, 5'h00};

    // Bit times in one frame of the bus; zero marks an illegal rate code
    function automatic logic [10:0] frame_len(input logic [2:0] rate);
        logic [10:0] len;
        len = 11'h000;
        case (rate)
            RATE_1536: len = LEN_1536;
            RATE_1544: len = LEN_1544;
            RATE_2048: len = LEN_2048;
            RATE_4096: len = LEN_4096;
            RATE_8192: len = LEN_8192;
            default: len = 11'h000;
        endcase
        return len;
    endfunction

endpackage

// ==== logic/rx_bus_sync_offset.sv ====
`timescale 1ns/100ps
`default_nettype none
module rx_bus_sync_offset (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [4:0] rx_sync_frame_position,
    input wire logic rx_bus_clock_in,
    input wire logic rx_frame_sync_in,
    output logic rx_frame_sync_out,
    output logic rx_frame_sync_oe_n,
    input wire logic rx_multiframe_sync_in,
    output logic rx_multiframe_sync_out,
    output logic rx_multiframe_sync_oe_n
);

    // Bus slave, system clock domain
    logic wr_pend_ff;
    logic rd_pend_ff;
    logic rd_done_ff;
    logic [11:0] addr_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] rd_val;
    logic take;
    logic wr_bit;
    logic wr_slot;
    logic wr_ctrl;
    logic wr_stat;

    assign take = hsel && htrans[1] && hready;
    // Reads take one wait state so the data comes from a flop
    assign hreadyout = !rd_pend_ff || rd_done_ff;
    assign hrdata = hrdata_ff;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            rd_done_ff <= 1'b0;
            addr_ff <= 12'h000;
        end else if (hready) begin
            wr_pend_ff <= take && hwrite;
            rd_pend_ff <= take && !hwrite;
            rd_done_ff <= 1'b0;
            if (take) begin
                addr_ff <= haddr[11:0];
            end
        end else begin
            rd_done_ff <= 1'b1;
        end
    end

    assign wr_bit = wr_pend_ff && (addr_ff == rx_sync_pkg::BIT_POS_ADDR);
    assign wr_slot = wr_pend_ff && (addr_ff == rx_sync_pkg::SLOT_POS_ADDR);
    assign wr_ctrl = wr_pend_ff && (addr_ff == rx_sync_pkg::CTRL_ADDR);
    assign wr_stat = wr_pend_ff && (addr_ff == rx_sync_pkg::STATUS_ADDR);

    // Registers
    logic [2:0] bit_pos_ff;
    logic [6:0] slot_pos_ff;
    logic [7:0] ctrl_ff;

    // Reserved bits are dropped on write and read back as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_pos_ff <= rx_sync_pkg::BIT_POS_RST;
        end else if (wr_bit) begin
            bit_pos_ff <= hwdata[2:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_pos_ff <= rx_sync_pkg::SLOT_POS_RST;
        end else if (wr_slot) begin
            slot_pos_ff <= hwdata[6:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= rx_sync_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= hwdata[7:0];
        end
    end

    rx_sync_pkg::sync_cfg_s cfg_now;
    logic [10:0] len_now;
    logic range_now;

    always_comb begin
        cfg_now.rate = ctrl_ff[rx_sync_pkg::CTRL_RATE_LSB +: 3];
        cfg_now.edge_sel = ctrl_ff[rx_sync_pkg::CTRL_EDGE_BIT];
        cfg_now.slip = ctrl_ff[rx_sync_pkg::CTRL_SLIP_LSB +: 2];
        cfg_now.fs_in = ctrl_ff[rx_sync_pkg::CTRL_FS_IN_BIT];
        cfg_now.ms_in = ctrl_ff[rx_sync_pkg::CTRL_MS_IN_BIT];
        cfg_now.pos = {slot_pos_ff, bit_pos_ff};
        cfg_now.frame = rx_sync_frame_position;
    end

    assign len_now = rx_sync_pkg::frame_len(cfg_now.rate);
    assign range_now = ({1'b0, cfg_now.pos} < len_now);

    // Slot and group as the bus rate reads the slot field
    logic [6:0] dec_slot;
    logic [1:0] dec_group;

    always_comb begin
        dec_slot = slot_pos_ff;
        dec_group = 2'h0;
        if (cfg_now.rate == rx_sync_pkg::RATE_4096) begin
            dec_slot = {1'b0, slot_pos_ff[6:1]};
            dec_group = {1'b0, slot_pos_ff[0]};
        end else if (cfg_now.rate == rx_sync_pkg::RATE_8192) begin
            dec_slot = {2'h0, slot_pos_ff[6:2]};
            dec_group = slot_pos_ff[1:0];
        end
    end

    // Input pulse events from the link domain, toggle crossing
    logic [1:0] evt_tgl_ff;
    logic [1:0] evt_s1_ff;
    logic [1:0] evt_s2_ff;
    logic [1:0] evt_s3_ff;
    logic [1:0] evt;
    logic [1:0] seen_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_s1_ff <= 2'h0;
            evt_s2_ff <= 2'h0;
            evt_s3_ff <= 2'h0;
        end else begin
            evt_s1_ff <= evt_tgl_ff;
            evt_s2_ff <= evt_s1_ff;
            evt_s3_ff <= evt_s2_ff;
        end
    end

    assign evt = evt_s2_ff ^ evt_s3_ff;

    // Write one clears; a new event in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_ff <= 2'h0;
        end else begin
            seen_ff <= evt | (seen_ff & ~({2{wr_stat}} &
                hwdata[rx_sync_pkg::STAT_FS_SEEN_BIT +: 2]));
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        case (addr_ff)
            rx_sync_pkg::BIT_POS_ADDR: rd_val[2:0] = bit_pos_ff;
            rx_sync_pkg::SLOT_POS_ADDR: rd_val[6:0] = slot_pos_ff;
            rx_sync_pkg::CTRL_ADDR: rd_val[7:0] = ctrl_ff;
            rx_sync_pkg::STATUS_ADDR: begin
                rd_val[rx_sync_pkg::STAT_RANGE_BIT] = range_now;
                rd_val[rx_sync_pkg::STAT_FS_SEEN_BIT +: 2] = seen_ff;
                rd_val[rx_sync_pkg::STAT_SLOT_LSB +: 7] = dec_slot;
                rd_val[rx_sync_pkg::STAT_GROUP_LSB +: 2] = dec_group;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_pend_ff && !rd_done_ff) begin
            hrdata_ff <= rd_val;
        end
    end

    // Configuration crossing: toggle request, hold stays put until acknowledged
    rx_sync_pkg::sync_cfg_s hold_ff;
    logic req_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;
    logic req_s1_ff;
    logic req_s2_ff;
    logic req_s3_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_ff <= rx_sync_pkg::CFG_RST;
            req_ff <= 1'b0;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end else begin
            ack_s1_ff <= req_s3_ff;
            ack_s2_ff <= ack_s1_ff;
            if ((req_ff == ack_s2_ff) && (cfg_now != hold_ff)) begin
                hold_ff <= cfg_now;
                req_ff <= !req_ff;
            end
        end
    end

    // Link domain reset: asserts at once, releases on the link clock
    logic [1:0] lrst_ff;
    logic lrst_n;

    always_ff @(posedge rx_bus_clock_in or negedge hresetn) begin
        if (!hresetn) begin
            lrst_ff <= 2'h0;
        end else begin
            lrst_ff <= {lrst_ff[0], 1'b1};
        end
    end

    assign lrst_n = lrst_ff[1];

    rx_sync_pkg::sync_cfg_s lcfg_ff;

    always_ff @(posedge rx_bus_clock_in or negedge lrst_n) begin
        if (!lrst_n) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
            lcfg_ff <= rx_sync_pkg::CFG_RST;
        end else begin
            req_s1_ff <= req_ff;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
            if (req_s2_ff != req_s3_ff) begin
                lcfg_ff <= hold_ff;
            end
        end
    end

    // Sync pins, one lane per pin: 0 frame sync, 1 multiframe sync
    logic [1:0] pin_in;
    logic [1:0] dir_in;
    logic [1:0] accept;
    logic [1:0] pulse_in;
    logic [1:0] hit;
    logic [1:0] out_rise_ff;
    logic [1:0] out_fall_ff;
    logic [1:0] oe_n_ff;
    logic [1:0] pin_out;

    assign pin_in = {rx_multiframe_sync_in, rx_frame_sync_in};
    assign dir_in = {lcfg_ff.ms_in, lcfg_ff.fs_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            logic neg1_ff;
            logic neg2_ff;
            logic pos1_ff;
            logic pos2_ff;
            logic samp;
            logic prev_ff;

            always_ff @(negedge rx_bus_clock_in or negedge lrst_n) begin
                if (!lrst_n) begin
                    neg1_ff <= 1'b0;
                    out_fall_ff[gi] <= 1'b0;
                end else begin
                    neg1_ff <= pin_in[gi];
                    out_fall_ff[gi] <= out_rise_ff[gi];
                end
            end

            always_ff @(posedge rx_bus_clock_in or negedge lrst_n) begin
                if (!lrst_n) begin
                    neg2_ff <= 1'b0;
                    pos1_ff <= 1'b0;
                    pos2_ff <= 1'b0;
                    prev_ff <= 1'b0;
                    out_rise_ff[gi] <= 1'b0;
                    oe_n_ff[gi] <= 1'b1;
                    evt_tgl_ff[gi] <= 1'b0;
                end else begin
                    neg2_ff <= neg1_ff;
                    pos1_ff <= pin_in[gi];
                    pos2_ff <= pos1_ff;
                    prev_ff <= samp;
                    out_rise_ff[gi] <= hit[gi] && !dir_in[gi];
                    oe_n_ff[gi] <= dir_in[gi];
                    evt_tgl_ff[gi] <= evt_tgl_ff[gi] ^ pulse_in[gi];
                end
            end

            assign samp = lcfg_ff.edge_sel ? pos2_ff : neg2_ff;
            assign pulse_in[gi] = samp && !prev_ff && accept[gi];
            assign pin_out[gi] = lcfg_ff.edge_sel ? out_fall_ff[gi] : out_rise_ff[gi];
        end
    endgenerate

    // Bypass mode deafens input sync pins
    assign accept = dir_in & {2{lcfg_ff.slip != rx_sync_pkg::SLIP_BYPASS}};

    // Bus timebase: bit counter in the frame holds {slot, group, bit}
    logic [9:0] bit_cnt_ff;
    logic [4:0] frm_cnt_ff;
    logic [10:0] len;
    logic in_range;
    logic mf_ok;

    assign len = rx_sync_pkg::frame_len(lcfg_ff.rate);
    assign in_range = ({1'b0, lcfg_ff.pos} < len);
    assign mf_ok = lcfg_ff.frame < rx_sync_pkg::MF_FRAMES;

    // Accepted pulses realign the timebase to the programmed spot
    always_ff @(posedge rx_bus_clock_in or negedge lrst_n) begin
        if (!lrst_n) begin
            bit_cnt_ff <= 10'h000;
            frm_cnt_ff <= 5'h00;
        end else if (pulse_in[1] && in_range && mf_ok) begin
            bit_cnt_ff <= lcfg_ff.pos;
            frm_cnt_ff <= lcfg_ff.frame;
        end else if (pulse_in[0] && in_range) begin
            bit_cnt_ff <= lcfg_ff.pos;
        end else if (({1'b0, bit_cnt_ff} + 11'h001) >= len) begin
            bit_cnt_ff <= 10'h000;
            if (frm_cnt_ff >= rx_sync_pkg::MF_FRAMES - 5'h01) begin
                frm_cnt_ff <= 5'h00;
            end else begin
                frm_cnt_ff <= frm_cnt_ff + 5'h01;
            end
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 10'h001;
        end
    end

    // One bit position for both pulses, counted against the output slots
    assign hit[0] = in_range && (bit_cnt_ff == lcfg_ff.pos);
    assign hit[1] = hit[0] && mf_ok && (frm_cnt_ff == lcfg_ff.frame);

    assign rx_frame_sync_out = pin_out[0];
    assign rx_multiframe_sync_out = pin_out[1];
    assign rx_frame_sync_oe_n = oe_n_ff[0];
    assign rx_multiframe_sync_oe_n = oe_n_ff[1];

endmodule
`default_nettype wire

// ==== sim/rx_bus_sync_offset_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module rx_bus_sync_offset_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic rx_bus_clock_in,
    input wire logic rx_frame_sync_out,
    input wire logic rx_frame_sync_oe_n,
    input wire logic rx_multiframe_sync_out
);
    logic take;
    logic rd_take;
    assign take = hsel && htrans[1] && hready;
    assign rd_take = take && !hwrite;
    resp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn) !hresp)
        else $error("response not okay");
    write_nowait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && hwrite |=> hreadyout) else $error("write stalled");
    read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    wait_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(hreadyout) |-> $past(rd_take)) else $error("stall without read");
    rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout |=> $stable(hrdata)) else $error("read data moved");
    // Sampled on rising edges, a falling-edge pulse still shows for exactly one sample
    fs_width_a: assert property (@(posedge rx_bus_clock_in) disable iff (!hresetn)
        rx_frame_sync_out |=> !rx_frame_sync_out) else $error("frame sync too wide");
    ms_width_a: assert property (@(posedge rx_bus_clock_in) disable iff (!hresetn)
        rx_multiframe_sync_out |-> ##1 !rx_multiframe_sync_out [*2])
        else $error("multiframe sync too wide");
    ms_with_fs_a: assert property (@(posedge rx_bus_clock_in) disable iff (!hresetn)
        rx_multiframe_sync_out && !rx_frame_sync_oe_n |-> rx_frame_sync_out)
        else $error("multiframe off frame bit");
    cover property (@(posedge hclk) rd_take);
    cover property (@(posedge rx_bus_clock_in) $rose(rx_frame_sync_out));
    cover property (@(posedge rx_bus_clock_in) rx_multiframe_sync_out);
endmodule
bind rx_bus_sync_offset rx_bus_sync_offset_chk rx_bus_sync_offset_chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rx_bus_clock_in(rx_bus_clock_in), .rx_frame_sync_out(rx_frame_sync_out),
    .rx_frame_sync_oe_n(rx_frame_sync_oe_n),
    .rx_multiframe_sync_out(rx_multiframe_sync_out));
`default_nettype wire

// ==== sim/sync_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module sync_partner (
    input wire logic rx_clk,
    input wire logic go,
    input wire logic fs_oe_n,
    input wire logic ms_oe_n,
    output logic fs_in,
    output logic ms_in
);
    logic flip = 1'b0;
    initial begin
        fs_in = 1'b0;
        ms_in = 1'b0;
    end
    // Launch on rising edges so a device sampling on falling edges sees settled data
    always @(posedge rx_clk) begin
        flip <= ~flip;
        // A pin the device drives is not ours: show a moving pattern, never a held level
        fs_in <= fs_oe_n ? go : flip;
        ms_in <= ms_oe_n ? go : ~flip;
    end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [2:0] rate;
        logic [9:0] pos;
        logic [6:0] slot;
        logic [1:0] grp;
        logic inr;
    } row_s;
    localparam logic [11:0] A_CT = rx_sync_pkg::CTRL_ADDR;
    localparam logic [11:0] A_ST = rx_sync_pkg::STATUS_ADDR;
    localparam logic [11:0] A_BP = rx_sync_pkg::BIT_POS_ADDR;
    localparam logic [11:0] A_SP = rx_sync_pkg::SLOT_POS_ADDR;
    row_s rows [10] = '{
        '{3'h0, 10'h0bf, 7'h17, 2'h0, 1'b1}, '{3'h1, 10'h0c0, 7'h18, 2'h0, 1'b1},
        '{3'h0, 10'h0c0, 7'h18, 2'h0, 1'b0}, '{3'h2, 10'h0ff, 7'h1f, 2'h0, 1'b1},
        '{3'h2, 10'h100, 7'h20, 2'h0, 1'b0}, '{3'h3, 10'h1ff, 7'h1f, 2'h1, 1'b1},
        '{3'h3, 10'h200, 7'h20, 2'h0, 1'b0}, '{3'h4, 10'h3ff, 7'h1f, 2'h3, 1'b1},
        '{3'h4, 10'h00a, 7'h00, 2'h1, 1'b1}, '{3'h5, 10'h005, 7'h00, 2'h0, 1'b0}};
    logic hclk = 1'b0;
    logic rx_clk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [4:0] fpos = 5'h03;
    logic go = 1'b0;
    logic hreadyout, hresp, fs_in, ms_in, fs_out, ms_out, fs_oe_n, ms_oe_n, fs_lvl;
    logic [31:0] hrdata;
    int errors = 0;
    int total_checks = 0;
    int fs_n = 0;
    int ms_n = 0;
    realtime fs_t, ms_t;
    always #10 hclk = ~hclk;
    // Odd start offset keeps the link clock out of step with the bus clock
    initial begin
        #1.3;
        forever #3 rx_clk = ~rx_clk;
    end
    rx_bus_sync_offset rx_bus_sync_offset_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .rx_sync_frame_position(fpos), .rx_bus_clock_in(rx_clk), .rx_frame_sync_in(fs_in),
        .rx_frame_sync_out(fs_out), .rx_frame_sync_oe_n(fs_oe_n),
        .rx_multiframe_sync_in(ms_in), .rx_multiframe_sync_out(ms_out),
        .rx_multiframe_sync_oe_n(ms_oe_n));
    sync_partner sync_partner_i (.rx_clk(rx_clk), .go(go), .fs_oe_n(fs_oe_n),
        .ms_oe_n(ms_oe_n), .fs_in(fs_in), .ms_in(ms_in));
    always @(posedge fs_out) begin
        fs_t = $realtime;
        fs_lvl = rx_clk;
        fs_n++;
    end
    always @(posedge ms_out) begin
        ms_t = $realtime;
        ms_n++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic hwait(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) n = 100;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] x;
        bus(a, 1'b0, 32'h0, x);
        check(x & m, e);
    endtask
    // The wait covers the handshake that carries the setting into the link domain
    task automatic setpos(input logic [9:0] p);
        wr(A_BP, {29'h0, p[2:0]});
        wr(A_SP, {25'h0, p[9:3]});
        hwait(10);
    endtask
    task automatic pulse_at(input logic ms, output realtime t);
        int n;
        int old;
        old = ms ? ms_n : fs_n;
        for (n = 0; n < 10000 && old == (ms ? ms_n : fs_n); n++) @(posedge rx_clk);
        if (n >= 10000) begin
            errors++;
            wrap_up();
        end
        t = ms ? ms_t : fs_t;
    endtask
    task automatic send_go();
        @(posedge rx_clk);
        go <= 1'b1;
        @(posedge rx_clk);
        go <= 1'b0;
        hwait(10);
    endtask
    function automatic logic [31:0] cyc(input realtime d);
        return int'(d / 6.0);
    endfunction
    initial begin
        realtime t0;
        realtime t1;
        logic [31:0] es;
        int i;
        hwait(6);
        hresetn <= 1'b1;
        for (i = 0; i < 10; i++) begin
            wr(A_CT, {29'h0, rows[i].rate});
            setpos(rows[i].pos);
            es = {19'h0, rows[i].grp, rows[i].slot, 3'h0, rows[i].inr};
            rd_chk(A_CT, 32'hffffffff, {29'h0, rows[i].rate});
            rd_chk(A_BP, 32'hffffffff, {29'h0, rows[i].pos[2:0]});
            rd_chk(A_SP, 32'hffffffff, {25'h0, rows[i].pos[9:3]});
            rd_chk(A_ST, 32'h1ff1, es);
        end
        $display("test decode rows done");
        wr(A_CT, 32'h2);
        setpos(10'h000);
        pulse_at(1'b0, t0);
        pulse_at(1'b0, t1);
        check(cyc(t1 - t0), 32'h100);
        check({31'h0, fs_lvl}, 32'h1);
        setpos(10'h02b);
        pulse_at(1'b0, t1);
        pulse_at(1'b0, t1);
        check(cyc(t1 - t0) % 32'h100, 32'h2b);
        wr(A_CT, 32'ha);
        hwait(10);
        pulse_at(1'b0, t1);
        check({31'h0, fs_lvl}, 32'h0);
        wr(A_CT, 32'h2);
        setpos(10'h100);
        i = fs_n + ms_n;
        repeat (600) @(posedge rx_clk);
        check(fs_n + ms_n, i);
        $display("test frame sync done");
        wr(A_CT, 32'h0);
        setpos(10'h005);
        pulse_at(1'b1, t0);
        pulse_at(1'b1, t1);
        check(cyc(t1 - t0), 32'h1200);
        hwait(1);
        fpos <= 5'h05;
        wr(A_CT, 32'h0);
        hwait(10);
        pulse_at(1'b1, t1);
        pulse_at(1'b1, t1);
        check(cyc(t1 - t0) % 32'h1200, 32'h180);
        hwait(1);
        fpos <= rx_sync_pkg::MF_FRAMES;
        wr(A_CT, 32'h0);
        hwait(10);
        i = ms_n;
        repeat (5000) @(posedge rx_clk);
        check(ms_n, i);
        $display("test multiframe done");
        wr(A_CT, 32'hc2);
        hwait(10);
        check({30'h0, fs_oe_n, ms_oe_n}, 32'h3);
        wr(A_ST, 32'h6);
        send_go();
        rd_chk(A_ST, 32'h6, 32'h6);
        wr(A_CT, 32'hca);
        hwait(10);
        wr(A_ST, 32'h6);
        send_go();
        rd_chk(A_ST, 32'h6, 32'h6);
        wr(A_CT, 32'hf2);
        hwait(10);
        wr(A_ST, 32'h6);
        send_go();
        rd_chk(A_ST, 32'h6, 32'h0);
        wr(A_CT, 32'h2);
        hwait(10);
        check({30'h0, fs_oe_n, ms_oe_n}, 32'h0);
        $display("test input pins done");
        hresetn <= 1'b0;
        hwait(3);
        check({28'h0, fs_out, ms_out, fs_oe_n, ms_oe_n}, 32'h3);
        check({31'h0, hresp}, 32'h0);
        hresetn <= 1'b1;
        rd_chk(A_BP, 32'hffffffff, {29'h0, rx_sync_pkg::BIT_POS_RST});
        rd_chk(A_SP, 32'hffffffff, {25'h0, rx_sync_pkg::SLOT_POS_RST});
        rd_chk(A_CT, 32'hffffffff, {24'h0, rx_sync_pkg::CTRL_RST});
        wr(12'h100, 32'h5);
        rd_chk(12'h100, 32'hffffffff, 32'h0);
        $display("test reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
